// ### design/roll_remap_defs.svh
/*
  Register offsets, field positions and reset values for the roll remap and
  local range decoder. Assumes inclusion by bare name from design files only.
*/
`ifndef ROLL_REMAP_DEFS_SVH
`define ROLL_REMAP_DEFS_SVH

// I/O offsets of the four registers
`define RRD_ROLL_A_OFS       8'h24
`define RRD_ROLL_B_OFS       8'h26
`define RRD_LOCAL_A_OFS      8'h28
`define RRD_LOCAL_B_OFS      8'h2a

// Roll window field layout
`define RRD_ROLL_EN_BIT      0
`define RRD_ROLL_MASK_LSB    2
`define RRD_ROLL_START_LSB   9

// Local range field layout
`define RRD_LOCAL_EN_BIT     0
`define RRD_LOCAL_MASK_LSB   4
`define RRD_LOCAL_START_LSB  11

// Local range A comes up enabled for a 512K space
`define RRD_LOCAL_A_RST_MASK 5'h1f

// First physical 128K block number usable as a roll target (080000H)
`define RRD_HOLE_FIRST_BLK   7'h04
`define RRD_HOLE_BLOCKS      4
`endif

// ### design/roll_remap_pkg.sv
/*
  Types for the roll remap and local range decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package roll_remap_pkg;

  // One roll window register
  typedef struct packed {
    logic       en;     // Window enable
    logic [6:0] start;  // Address bits 23..17 of first address
    logic [6:0] mask;   // Set bits take part in compare
  } roll_window_type;

  // One local range register
  typedef struct packed {
    logic       en;     // Range enable
    logic [4:0] start;  // Address bits 23..19
    logic [4:0] mask;   // Set bits take part in compare
  } local_range_type;

  // Two-bit legacy bus status {one_n, zero_n}
  typedef enum logic [1:0] {
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10,
    BUS_IDLE  = 2'b11
  } bus_status_type;

endpackage

// ### design/roll_remap_and_local_range_decode.sv
/*
  Roll address remapping and local/off-board decode for the memory controller,
  with its four I/O registers. Assumes one cycle descriptor per i_cyc_start
  pulse, all inputs from logic on i_mclk, and lock and shadow selects supplied
  as levels by the configuration register outside this block.
*/
// Summary of operation
// - Rolled addresses drive translated DRAM address
// - Roll capacity: one 128K per unused block
// - Set mask bits compare address to start
// - Disabled window never rolls
// - Reset clears both window enables
// - Windows at 24H, 26H until locked
// - Local hit drives on-board indication high
// - Non-local drives status outputs off-board
// - Roll translation precedes local compare
// - Both local ranges ORed together
// - Local mask bits 23..19 set size
// - Unshadowed holes above 512K are non-local
// - Disabled ranges ignored; none means off-board
// - Reset enables range A at 512K
// - Ranges at 28H, 2AH until locked
// - Writes overwrite all register fields
`include "roll_remap_defs.svh"

module roll_remap_and_local_range_decode #(
  parameter int ADDR_W = 24                          // Processor address width
) (
  input  wire logic              i_mclk,             // Processor clock
  input  wire logic              i_srst,             // System reset, sync high
  input  wire logic              i_cyc_start,        // Cycle start pulse
  input  wire logic              i_cyc_mem,          // 1 memory, 0 I/O
  input  wire logic              i_cyc_write,        // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] i_cyc_addr,         // Byte address
  input  wire logic [15:0]       i_cyc_wdata,        // I/O write data
  input  wire logic              i_cfg_lock,         // Configuration lock level
  input  wire logic              i_base_size_select, // 0 512K base, 1 640K
  input  wire logic              i_bios_shadow_select_n,    // 1 BIOS shadowed
  input  wire logic              i_adapter_shadow_select_n, // 1 adapter shadowed
  input  wire logic              i_video_shadow_select_n,   // 1 video shadowed
  input  wire logic              i_col_select,       // 0 row, 1 column phase
  output logic [15:0]            o_io_rdata,         // Register read data
  output logic                   o_reg_claim,        // Register access taken
  output logic                   o_on_board_hit,     // Local DRAM access
  output logic                   o_bus_status_zero_n,  // Legacy status 0
  output logic                   o_bus_status_one_n,   // Legacy status 1
  output logic                   o_legacy_mem_or_io_n, // 1 memory, 0 I/O
  output logic [ADDR_W-1:0]      o_phys_addr,        // Translated address
  output logic [9:0]             o_dram_row_col_addr // Multiplexed DRAM address
);

  // Logic is built for the 24-bit processor address only
  if (ADDR_W != 24) begin : g_bad_width
    $error("ADDR_W must be 24");
  end

  // Register file state
  roll_remap_pkg::roll_window_type win_q [2];
  roll_remap_pkg::roll_window_type win_d [2];
  roll_remap_pkg::local_range_type rng_q [2];
  roll_remap_pkg::local_range_type rng_d [2];

  // Output state
  logic [15:0]       rdata_q, rdata_d;          // Held read data
  logic              claim_q, claim_d;          // One-cycle claim
  logic              hit_q, hit_d;              // Held on-board level
  logic [1:0]        stat_q, stat_d;            // One-cycle status
  logic              mio_q, mio_d;              // Held memory/IO level
  logic [ADDR_W-1:0] phys_q, phys_d;            // Held physical address
  logic [9:0]        dram_q, dram_d;            // Muxed DRAM address

  // Decode intermediates
  logic [3:0]        hole_free;                 // Block unused by shadow/base
  logic [2:0]        win_hit;                   // Window A hit, window B hit, either hit
  logic              roll_ok;                   // Slot has a target block
  logic [6:0]        roll_blk;                  // Target block number
  logic [ADDR_W-1:0] xlat;                      // Address after roll
  logic              in_range;                  // Local range match
  logic              in_hole;                   // Unshadowed hole
  logic              local_hit;                 // Final local decision
  logic              reg_sel;                   // Register offset decoded
  logic [1:0]        reg_idx;                   // Which register
  logic [2:0]        seen;                      // Free blocks counted so far

  // Roll window compare on address bits 23..17
  function automatic logic win_match(input roll_remap_pkg::roll_window_type w,
                                     input logic [6:0] a);
    win_match = w.en && (((a ^ w.start) & w.mask) == 7'h00);
  endfunction

  // Local range compare on address bits 23..19
  function automatic logic rng_match(input roll_remap_pkg::local_range_type r,
                                     input logic [4:0] a);
    rng_match = r.en && (((a ^ r.start) & r.mask) == 5'h00);
  endfunction

  // Readback of a roll window, spare bits zero
  function automatic logic [15:0] win_pack(input roll_remap_pkg::roll_window_type w);
    win_pack = 16'h0000;
    win_pack[`RRD_ROLL_EN_BIT] = w.en;
    win_pack[`RRD_ROLL_MASK_LSB +: 7] = w.mask;
    win_pack[`RRD_ROLL_START_LSB +: 7] = w.start;
  endfunction

  // Readback of a local range, spare bits zero
  function automatic logic [15:0] rng_pack(input roll_remap_pkg::local_range_type r);
    rng_pack = 16'h0000;
    rng_pack[`RRD_LOCAL_EN_BIT] = r.en;
    rng_pack[`RRD_LOCAL_MASK_LSB +: 5] = r.mask;
    rng_pack[`RRD_LOCAL_START_LSB +: 5] = r.start;
  endfunction

  // Roll translation and local/off-board decode
  always_comb
  begin
    // Free blocks 080000H, 0A0000H, 0C0000H, 0E0000H in that order
    hole_free[0] = !i_base_size_select;
    hole_free[1] = !i_video_shadow_select_n;
    hole_free[2] = !i_adapter_shadow_select_n;
    hole_free[3] = !i_bios_shadow_select_n;
    win_hit[0] = win_match(win_q[0], i_cyc_addr[23:17]);
    win_hit[1] = win_match(win_q[1], i_cyc_addr[23:17]);
    win_hit[2] = win_hit[0] | win_hit[1];
    // Slot in the 512K roll area picks the n-th free block
    roll_ok  = 1'b0;
    roll_blk = `RRD_HOLE_FIRST_BLK;
    begin
      seen = 3'd0;
      for (int k = 0; k < `RRD_HOLE_BLOCKS; k++)
      begin
        if (hole_free[k])
        begin
          if (!roll_ok && (seen == {1'b0, i_cyc_addr[18:17]}))
          begin
            roll_ok  = 1'b1;
            roll_blk = `RRD_HOLE_FIRST_BLK | 7'(k);
          end
          seen = seen + 3'd1;
        end
      end
    end
    // Translate first, then compare against local ranges
    if (win_hit[2] && roll_ok)
    begin
      xlat = {roll_blk, i_cyc_addr[16:0]};
    end
    else
    begin
      xlat = i_cyc_addr;
    end
    in_range = rng_match(rng_q[0], xlat[23:19]) |
               rng_match(rng_q[1], xlat[23:19]);
    // Holes apply only to untranslated accesses
    in_hole = 1'b0;
    for (int k = 0; k < `RRD_HOLE_BLOCKS; k++)
    begin
      if (hole_free[k] && (i_cyc_addr[23:17] == (`RRD_HOLE_FIRST_BLK | 7'(k))))
      begin
        in_hole = 1'b1;
      end
    end
    local_hit = in_range && ((win_hit[2] && roll_ok) || !in_hole);
    // Register decode on even I/O offsets while unlocked
    reg_sel = 1'b0;
    reg_idx = 2'd0;
    if (!i_cyc_mem && !i_cfg_lock && (i_cyc_addr[23:8] == 16'h0000))
    begin
      unique case (i_cyc_addr[7:0])
        `RRD_ROLL_A_OFS:  begin reg_sel = 1'b1; reg_idx = 2'd0; end
        `RRD_ROLL_B_OFS:  begin reg_sel = 1'b1; reg_idx = 2'd1; end
        `RRD_LOCAL_A_OFS: begin reg_sel = 1'b1; reg_idx = 2'd2; end
        `RRD_LOCAL_B_OFS: begin reg_sel = 1'b1; reg_idx = 2'd3; end
        default:          begin reg_sel = 1'b0; reg_idx = 2'd0; end
      endcase
    end
  end

  // Next state of registers and outputs
  always_comb
  begin
    win_d   = win_q;
    rng_d   = rng_q;
    rdata_d = rdata_q;
    claim_d = 1'b0;
    hit_d   = hit_q;
    stat_d  = roll_remap_pkg::BUS_IDLE;
    mio_d   = mio_q;
    phys_d  = phys_q;
    // Row or column half of the held physical word address
    dram_d  = i_col_select ? phys_q[10:1] : phys_q[20:11];
    if (i_cyc_start)
    begin
      if (reg_sel)
      begin
        // Register access stays inside the device
        claim_d = 1'b1;
        if (i_cyc_write)
        begin
          unique case (reg_idx)
            2'd0, 2'd1:
            begin
              // Whole register overwritten
              win_d[reg_idx[0]].en    = i_cyc_wdata[`RRD_ROLL_EN_BIT];
              win_d[reg_idx[0]].mask  = i_cyc_wdata[`RRD_ROLL_MASK_LSB +: 7];
              win_d[reg_idx[0]].start = i_cyc_wdata[`RRD_ROLL_START_LSB +: 7];
            end
            2'd2, 2'd3:
            begin
              rng_d[reg_idx[0]].en    = i_cyc_wdata[`RRD_LOCAL_EN_BIT];
              rng_d[reg_idx[0]].mask  = i_cyc_wdata[`RRD_LOCAL_MASK_LSB +: 5];
              rng_d[reg_idx[0]].start = i_cyc_wdata[`RRD_LOCAL_START_LSB +: 5];
            end
          endcase
        end
        else
        begin
          rdata_d = reg_idx[1] ? rng_pack(rng_q[reg_idx[0]]) : win_pack(win_q[reg_idx[0]]);
        end
      end
      else if (i_cyc_mem)
      begin
        phys_d = xlat;
        hit_d  = local_hit;
        mio_d  = 1'b1;
        if (!local_hit)
        begin
          // Off-board memory cycle on the legacy bus
          stat_d = i_cyc_write ? roll_remap_pkg::BUS_WRITE : roll_remap_pkg::BUS_READ;
        end
      end
      else
      begin
        // Other I/O, and locked register offsets, go off-board
        hit_d  = 1'b0;
        mio_d  = 1'b0;
        stat_d = i_cyc_write ? roll_remap_pkg::BUS_WRITE : roll_remap_pkg::BUS_READ;
      end
    end
  end

  // State registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      win_q[0] <= '0;
      win_q[1] <= '0;
      rng_q[0] <= '{en: 1'b1, start: 5'h00, mask: `RRD_LOCAL_A_RST_MASK};
      rng_q[1] <= '0;
      rdata_q  <= 16'h0000;
      claim_q  <= 1'b0;
      hit_q    <= 1'b0;
      stat_q   <= roll_remap_pkg::BUS_IDLE;
      mio_q    <= 1'b1;
      phys_q   <= '0;
      dram_q   <= 10'h000;
    end
    else
    begin
      win_q   <= win_d;
      rng_q   <= rng_d;
      rdata_q <= rdata_d;
      claim_q <= claim_d;
      hit_q   <= hit_d;
      stat_q  <= stat_d;
      mio_q   <= mio_d;
      phys_q  <= phys_d;
      dram_q  <= dram_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_io_rdata           = rdata_q;
  assign o_reg_claim          = claim_q;
  assign o_on_board_hit       = hit_q;
  assign o_bus_status_zero_n  = stat_q[0];
  assign o_bus_status_one_n   = stat_q[1];
  assign o_legacy_mem_or_io_n = mio_q;
  assign o_phys_addr          = phys_q;
  assign o_dram_row_col_addr  = dram_q;

endmodule

// ### testbench/roll_remap_checker.sv
/* Port-level checks for the roll remap and local range decoder.
   Bound to the decoder; one clock, synchronous reset. */
module roll_remap_checker #(
  parameter int ADDR_W = 24
) (
  input wire logic              i_mclk,
  input wire logic              i_srst,
  input wire logic              i_cyc_start,
  input wire logic              i_cyc_mem,
  input wire logic              i_cyc_write,
  input wire logic [ADDR_W-1:0] i_cyc_addr,
  input wire logic              i_cfg_lock,
  input wire logic              i_base_size_select,
  input wire logic              i_video_shadow_select_n,
  input wire logic              i_col_select,
  input wire logic              o_reg_claim,
  input wire logic              o_on_board_hit,
  input wire logic              o_bus_status_zero_n,
  input wire logic              o_bus_status_one_n,
  input wire logic              o_legacy_mem_or_io_n,
  input wire logic [ADDR_W-1:0] o_phys_addr,
  input wire logic [9:0]        o_dram_row_col_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  // Memory cycle taken at this edge
  logic mem_go;
  assign mem_go = i_cyc_start && i_cyc_mem;
  chk_claim_cause: assert property (o_reg_claim |-> $past(i_cyc_start && !i_cyc_mem && !i_cfg_lock))
    else $error("claim without unlocked io cycle");
  chk_lock_refuse: assert property (i_cyc_start && i_cfg_lock |=> !o_reg_claim)
    else $error("locked access claimed");
  chk_local_status: assert property (mem_go |=> o_on_board_hit == (o_bus_status_zero_n && o_bus_status_one_n))
    else $error("hit and status disagree");
  chk_status_cause: assert property (!(o_bus_status_zero_n && o_bus_status_one_n) |-> $past(i_cyc_start))
    else $error("status without cycle");
  chk_write_code: assert property (i_cyc_start && i_cyc_write |=> o_bus_status_one_n)
    else $error("write gave read code");
  chk_read_code: assert property (i_cyc_start && !i_cyc_write |=> o_bus_status_zero_n)
    else $error("read gave write code");
  chk_mem_flag: assert property (mem_go |=> o_legacy_mem_or_io_n)
    else $error("memory cycle flagged io");
  chk_low_bits: assert property (mem_go |=> o_phys_addr[16:0] == $past(i_cyc_addr[16:0]))
    else $error("offset in block changed");
  chk_dram_mux: assert property (o_dram_row_col_addr ==
    ($past(i_col_select) ? $past(o_phys_addr[10:1]) : $past(o_phys_addr[20:11])))
    else $error("dram address mux wrong");
  chk_hole_offboard: assert property (mem_go && ((i_cyc_addr[23:17] == 7'h04 && !i_base_size_select) ||
    (i_cyc_addr[23:17] == 7'h05 && !i_video_shadow_select_n)) |=> !o_on_board_hit)
    else $error("hole decoded local");
  // Main scenarios reached
  cov_local: cover property (mem_go ##1 o_on_board_hit);
  cov_offboard: cover property (mem_go ##1 !o_on_board_hit);
  cov_claim: cover property (o_reg_claim);
endmodule

bind roll_remap_and_local_range_decode roll_remap_checker #(.ADDR_W(ADDR_W)) u_checker (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_cyc_start(i_cyc_start), .i_cyc_mem(i_cyc_mem),
  .i_cyc_write(i_cyc_write), .i_cyc_addr(i_cyc_addr), .i_cfg_lock(i_cfg_lock),
  .i_base_size_select(i_base_size_select), .i_video_shadow_select_n(i_video_shadow_select_n),
  .i_col_select(i_col_select), .o_reg_claim(o_reg_claim), .o_on_board_hit(o_on_board_hit),
  .o_bus_status_zero_n(o_bus_status_zero_n), .o_bus_status_one_n(o_bus_status_one_n),
  .o_legacy_mem_or_io_n(o_legacy_mem_or_io_n), .o_phys_addr(o_phys_addr),
  .o_dram_row_col_addr(o_dram_row_col_addr));

// ### testbench/off_board_bus_model.sv
/* Off-board bus side: counts read and write status pulses.
   Assumes active-low status sampled on the processor clock. */
module off_board_bus_model (
  input  wire logic i_mclk,
  input  wire logic i_bus_status_zero_n,
  input  wire logic i_bus_status_one_n,
  output int        o_rd_cnt,
  output int        o_wr_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Count each off-board access by its status code
  always @(posedge i_mclk)
  begin
    o_rd_cnt <= o_rd_cnt + int'(!i_bus_status_one_n && i_bus_status_zero_n);
    o_wr_cnt <= o_wr_cnt + int'(i_bus_status_one_n && !i_bus_status_zero_n);
  end
  initial
  begin
    o_rd_cnt = 0;
    o_wr_cnt = 0;
  end
endmodule

// ### testbench/roll_remap_and_local_range_decode_tb_top.sv
/* Self-checking bench for the roll remap and local range decoder.
   Reference decode held in plain logic vectors; registers via I/O cycles. */
module roll_remap_and_local_range_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk, i_srst, i_cyc_start, i_cyc_mem, i_cyc_write, i_cfg_lock, i_col_select;
  logic        i_base_size_select, i_bios_shadow_select_n, i_adapter_shadow_select_n, i_video_shadow_select_n;
  logic [23:0] i_cyc_addr, o_phys_addr;
  logic [15:0] i_cyc_wdata, o_io_rdata;
  logic [9:0]  o_dram_row_col_addr;
  logic        o_reg_claim, o_on_board_hit, o_bus_status_zero_n, o_bus_status_one_n, o_legacy_mem_or_io_n;
  int          error_cnt, n_tests, seed, exp_rd, exp_wr, rd_cnt, wr_cnt;
  int          cyc_cnt = 0;                         // Hang guard
  logic [15:0] rg [4];                              // Reference registers
  logic [6:0]  st;                                  // Roll start in use
  logic [6:0]  rmk [3] = '{7'h7f, 7'h7e, 7'h7c};    // 128K, 256K, 512K
  logic [4:0]  lmk [5] = '{5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10};
  roll_remap_and_local_range_decode DUT (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_cyc_start(i_cyc_start), .i_cyc_mem(i_cyc_mem),
    .i_cyc_write(i_cyc_write), .i_cyc_addr(i_cyc_addr), .i_cyc_wdata(i_cyc_wdata), .i_cfg_lock(i_cfg_lock),
    .i_base_size_select(i_base_size_select), .i_bios_shadow_select_n(i_bios_shadow_select_n),
    .i_adapter_shadow_select_n(i_adapter_shadow_select_n), .i_video_shadow_select_n(i_video_shadow_select_n),
    .i_col_select(i_col_select), .o_io_rdata(o_io_rdata), .o_reg_claim(o_reg_claim),
    .o_on_board_hit(o_on_board_hit), .o_bus_status_zero_n(o_bus_status_zero_n),
    .o_bus_status_one_n(o_bus_status_one_n), .o_legacy_mem_or_io_n(o_legacy_mem_or_io_n),
    .o_phys_addr(o_phys_addr), .o_dram_row_col_addr(o_dram_row_col_addr));
  off_board_bus_model u_bus (.i_mclk(i_mclk), .i_bus_status_zero_n(o_bus_status_zero_n),
    .i_bus_status_one_n(o_bus_status_one_n), .o_rd_cnt(rd_cnt), .o_wr_cnt(wr_cnt));
  // Free-running clock
  initial
  begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Cut a hang short
  always @(posedge i_mclk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // Counts and verdict
  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Window or range match on set mask bits
  function automatic logic mt(input logic [15:0] r, input logic [6:0] b, input logic loc);
    if (loc)
      return r[0] && (((b[6:2] ^ r[15:11]) & r[8:4]) == 5'h00);
    return r[0] && (((b ^ r[15:9]) & r[8:2]) == 7'h00);
  endfunction
  // Reference decode, returns {hit, phys}
  function automatic logic [24:0] ref_dec(input logic [23:0] a);
    logic [3:0] fr;
    logic [6:0] blk;
    logic       rl;
    int         n;
    fr = ~{i_bios_shadow_select_n, i_adapter_shadow_select_n, i_video_shadow_select_n, i_base_size_select};
    blk = a[23:17];
    rl = 0;
    n = int'(a[18:17]);
    if (mt(rg[0], blk, 0) || mt(rg[1], blk, 0))
      for (int i = 0; i < 4; i++)
        if (fr[i] && !rl)
        begin
          rl = (n == 0);
          blk = rl ? 7'(4 + i) : blk;
          n--;
        end
    return {(mt(rg[2], blk, 1) || mt(rg[3], blk, 1)) && (rl || !(blk inside {[4:7]} && fr[blk[1:0]])),
      blk, a[16:0]};
  endfunction
  // One processor cycle, answer check, then DRAM mux check on memory cycles
  task automatic cyc(input logic m, input logic w, input logic [23:0] a, input logic [15:0] d);
    logic [24:0] e;
    logic [1:0]  s;
    logic        rh;
    logic        c;
    int          ix;
    @(posedge i_mclk);
    e = ref_dec(a);
    rh = !m && !i_cfg_lock && a[23:8] == 16'h0000 && a[7:0] inside {8'h24, 8'h26, 8'h28, 8'h2a};
    ix = int'((a[7:0] - 8'h24) >> 1);
    s = (rh || (m && e[24])) ? 2'b11 : {w, !w};
    c = 1'($random(seed));
    i_cyc_start <= 1;
    i_cyc_mem <= m;
    i_cyc_write <= w;
    i_cyc_addr <= a;
    i_cyc_wdata <= d;
    i_col_select <= c;
    @(posedge i_mclk);
    i_cyc_start <= 0;
    #1;
    chk(24'(o_reg_claim), 24'(rh));
    chk(24'({o_bus_status_one_n, o_bus_status_zero_n}), 24'(s));
    exp_rd += int'(s == 2'b01);
    exp_wr += int'(s == 2'b10);
    if (rh && !w)
      chk(24'(o_io_rdata), 24'(rg[ix]));
    if (rh && w)
      rg[ix] = d & (ix < 2 ? 16'hfffd : 16'hf9f1);
    if (!rh)
      chk(24'(o_legacy_mem_or_io_n), 24'(m));
    if (m)
    begin
      chk(24'(o_on_board_hit), 24'(e[24]));
      chk(o_phys_addr, e[23:0]);
      @(posedge i_mclk);
      #1;
      chk(24'(o_dram_row_col_addr), 24'(c ? e[10:1] : e[20:11]));
    end
  endtask
  // Read back all four registers
  task automatic read_all;
    for (int k = 0; k < 4; k++)
      cyc(0, 0, 24'(8'h24 + 8'(2 * k)), 16'h0000);
  endtask
  // Main sequence
  initial
  begin
    seed = 32'h8d2d;
    {i_srst, i_cyc_start, i_cyc_mem, i_cyc_write, i_cfg_lock, i_col_select} = 6'b100000;
    {i_base_size_select, i_bios_shadow_select_n, i_adapter_shadow_select_n, i_video_shadow_select_n} = 4'hf;
    i_cyc_addr = 24'h000000;
    i_cyc_wdata = 16'h0000;
    rg = '{16'h0000, 16'h0000, 16'h01f1, 16'h0000};
    repeat (6) @(posedge i_mclk);
    i_srst <= 0;
    read_all();
    for (int k = 0; k < 4; k++)
      cyc(0, 1, 24'(8'h24 + 8'(2 * k)), 16'hffff);
    read_all();
    cyc(0, 0, 24'h00002c, 16'h0000);
    cyc(0, 1, 24'h000025, 16'h0000);
    cyc(0, 0, 24'h010028, 16'h0000);
    for (int k = 0; k < 60; k++)
    begin
      // Roll region above every local range size, on a 512K boundary
      st = 7'h40 | (7'($random(seed)) & 7'h3c);
      cyc(0, 1, 24'h000024, {st, rmk[k % 3], 1'($random(seed)), 1'(k % 4 != 0)});
      // Second window only as the 128K block just after a 256K first window
      cyc(0, 1, 24'h000026, {st | 7'h02, 7'h7f, 1'($random(seed)), 1'(k % 3 == 1 && k % 4 != 0)});
      cyc(0, 1, 24'h000028, {5'h00, 2'($random(seed)), lmk[k % 5], 3'($random(seed)), 1'(k % 7 != 0)});
      cyc(0, 1, 24'h00002a, (16'($random(seed)) & 16'h07fe) | 16'(k % 5 == 1));
      @(posedge i_mclk);
      {i_base_size_select, i_bios_shadow_select_n, i_adapter_shadow_select_n, i_video_shadow_select_n} <=
        4'($random(seed));
      for (int j = 0; j < 12; j++)
        cyc(1, 1'($random(seed)), 1'($random(seed)) ? {st[6:2], 19'($random(seed))} :
          24'($random(seed)) & 24'h1fffff, 16'h0000);
    end
    @(posedge i_mclk);
    i_cfg_lock <= 1;
    cyc(0, 1, 24'h000024, 16'hffff);
    cyc(0, 0, 24'h00002a, 16'h0000);
    // Lock dropped by hand: the refused write must not have landed
    @(posedge i_mclk);
    i_cfg_lock <= 0;
    cyc(0, 0, 24'h000024, 16'h0000);
    @(posedge i_mclk);
    i_srst <= 1;
    repeat (2) @(posedge i_mclk);
    i_srst <= 0;
    i_cfg_lock <= 0;
    rg = '{16'h0000, 16'h0000, 16'h01f1, 16'h0000};
    read_all();
    chk(24'(rd_cnt), 24'(exp_rd));
    chk(24'(wr_cnt), 24'(exp_wr));
    wrap_up();
  end
endmodule
